//--- common/pric_pkg.sv
// constants and register map of the prioritized interrupt controller
package pric_pkg;
  localparam int NUM_TRAP = 4;
  localparam int NUM_USER = 4;
  localparam int NUM_CAND = 8;
  localparam int LVL_W = 4;
  localparam int PRIO_W = 3;
  localparam int VEC_W = 7;
  localparam int IDX_W = 3;
  localparam int SP_W = 5;
  localparam int STACK_DEPTH = 16;
  localparam int DIS_W = 14;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int NUM_EV = 4;

  localparam logic [ADDR_W-1:0] OFF_CTRL1 = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_FLAGS = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_ENABLE = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_UERR_PRIO = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_PRIO = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_LVLVEC = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_CPU = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_DIS = 8'h1C;
  localparam logic [ADDR_W-1:0] OFF_ISTAT = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_IMASK = 8'h24;

  localparam int NEST_DIS_BIT = 15;
  localparam int TRAP_LSB = 1;
  localparam int LVL_LSB = 8;
  localparam int VEC_LSB = 0;
  // field position of each user priority; source 0 sits alone in its reg
  localparam int PRIO_LSB [NUM_USER] = '{4, 12, 8, 4};

  localparam logic [PRIO_W-1:0] PRIO_RESET = 3'h4;
  localparam logic [PRIO_W-1:0] PRIO_OFF = 3'h0;
  localparam logic [PRIO_W-1:0] PRIO_TOP = 3'h7;
  localparam logic [LVL_W-1:0] LVL_USER_TOP = 4'h7;
  localparam logic [LVL_W-1:0] LVL_ZERO = 4'h0;
  localparam logic [LVL_W-1:0] TRAP_LVL_BASE = 4'h8;

  localparam int EV_ACCEPT = 0;
  localparam int EV_TRAP = 1;
  localparam int EV_OVERFLOW = 2;
  localparam int EV_UNDERFLOW = 3;
endpackage

//--- common/pric_arb_if.sv
// candidate requests and the arbitration winner
interface pric_arb_if;
  import pric_pkg::*;
  logic [NUM_CAND-1:0] eligible;
  logic [LVL_W-1:0] level [NUM_CAND];
  logic win_valid;
  logic [IDX_W-1:0] win_idx;
  logic [LVL_W-1:0] win_level;
  modport arb (input eligible, input level,
    output win_valid, output win_idx, output win_level);
  modport ctl (output eligible, output level,
    input win_valid, input win_idx, input win_level);
endinterface

//--- core/pric_arb.sv
// highest level eligible candidate, lowest index on a tie
module pric_arb
  import pric_pkg::*;
(
  pric_arb_if.arb arb
);
  always_comb begin
    arb.win_valid = 1'b0;
    arb.win_idx = '0;
    arb.win_level = LVL_ZERO;
    // scanning downward with >= leaves the lowest index among equals
    for (int i = NUM_CAND - 1; i >= 0; i--) begin
      if (arb.eligible[i] &&
          (!arb.win_valid || arb.level[i] >= arb.win_level)) begin
        arb.win_valid = 1'b1;
        arb.win_idx = IDX_W'(i);
        arb.win_level = arb.level[i];
      end
    end
  end
endmodule

//--- core/pric_top.sv
// prioritized interrupt controller with apb registers and core handshake
//
// Decided for this implementation: the register addresses and the APB slave port.
module pric_top
  import pric_pkg::*;
(
  input wire logic SYS_CLK_IN,
  input wire logic SRST_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [pric_pkg::ADDR_W-1:0] PADDR_IN,
  input wire logic [pric_pkg::DATA_W-1:0] PWDATA_IN,
  output logic [pric_pkg::DATA_W-1:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  input wire logic [pric_pkg::NUM_USER-1:0] SRC_EVENT_IN,
  input wire logic [pric_pkg::NUM_TRAP-1:0] TRAP_EVENT_IN,
  input wire logic IRQ_ACK_IN,
  input wire logic IRQ_RETURN_IN,
  input wire logic TIMED_DISABLE_IN,
  input wire logic [pric_pkg::DIS_W-1:0] TIMED_DISABLE_CYCLES_IN,
  output logic CORE_REQ_OUT,
  output logic [pric_pkg::LVL_W-1:0] CORE_NEW_LEVEL_OUT,
  output logic [pric_pkg::VEC_W-1:0] CORE_VECTOR_OUT,
  output logic [pric_pkg::LVL_W-1:0] CPU_LEVEL_OUT,
  output logic IRQ_OUT
);
  import pric_pkg::*;

  logic nesting_disable;
  logic [NUM_TRAP-1:0] trap_flag;
  logic [NUM_USER-1:0] user_flag;
  logic [NUM_USER-1:0] user_enable;
  logic [PRIO_W-1:0] user_prio [NUM_USER];
  logic [LVL_W-1:0] cpu_level;
  logic [LVL_W-1:0] level_stack [STACK_DEPTH];
  logic [SP_W-1:0] sp;
  logic [DIS_W-1:0] dis_count;
  logic [NUM_EV-1:0] istat;
  logic [NUM_EV-1:0] imask;
  logic [IDX_W-1:0] pend_idx;
  logic [DATA_W-1:0] rd_data;
  logic rd_err;
  logic wr_fire;
  logic ack_fire;
  logic ret_fire;
  logic push_ok;
  logic pop_ok;
  logic dis_active;
  logic [NUM_EV-1:0] ev;
  logic [LVL_W-1:0] next_level;

  pric_arb_if arb_bus ();

  // the winner is combinational; the request flop adds the only delay
  pric_arb u_arb (
    .arb(arb_bus.arb)
  );

  // one wait state: pready rises in the second access cycle
  assign wr_fire = PSEL_IN & PENABLE_IN & PWRITE_IN & PREADY_OUT;
  assign ack_fire = IRQ_ACK_IN & CORE_REQ_OUT;
  assign ret_fire = IRQ_RETURN_IN;
  assign push_ok = (sp != SP_W'(STACK_DEPTH));
  assign pop_ok = (sp != '0);
  assign dis_active = (dis_count != '0);

  function automatic logic wr_at(input logic [ADDR_W-1:0] off);
    return wr_fire && (PADDR_IN == off);
  endfunction

  // candidate table: traps at indices 0..3, user sources after them
  always_comb begin
    for (int t = 0; t < NUM_TRAP; t++) begin
      arb_bus.level[t] = TRAP_LVL_BASE + LVL_W'(t);
      // traps ignore enables and timed disable
      arb_bus.eligible[t] = trap_flag[t] &&
        (arb_bus.level[t] > cpu_level);
    end
    for (int u = 0; u < NUM_USER; u++) begin
      arb_bus.level[NUM_TRAP+u] = {1'b0, user_prio[u]};
      arb_bus.eligible[NUM_TRAP+u] = user_flag[u] &&
        user_enable[u] &&
        (user_prio[u] != PRIO_OFF) &&
        ({1'b0, user_prio[u]} > cpu_level) &&
        !(dis_active && user_prio[u] != PRIO_TOP);
    end
  end

  // registered presentation to the core
  always_ff @(posedge SYS_CLK_IN) begin
    if (SRST_IN) begin
      CORE_REQ_OUT <= 1'b0;
      CORE_NEW_LEVEL_OUT <= LVL_ZERO;
      CORE_VECTOR_OUT <= '0;
      pend_idx <= '0;
    end else begin
      // drop the request for a cycle after ack so the raised level settles
      CORE_REQ_OUT <= arb_bus.win_valid & ~ack_fire;
      if (arb_bus.win_valid) begin
        CORE_NEW_LEVEL_OUT <= arb_bus.win_level;
        CORE_VECTOR_OUT <= VEC_W'(arb_bus.win_idx);
        pend_idx <= arb_bus.win_idx;
      end else begin
        CORE_NEW_LEVEL_OUT <= cpu_level;
        CORE_VECTOR_OUT <= '0;
      end
    end
  end

  // level raised on accept; nesting disable pins user service at seven
  always_comb begin
    next_level = CORE_NEW_LEVEL_OUT;
    // traps keep nesting above seven even with nesting disabled
    if (nesting_disable && (pend_idx >= IDX_W'(NUM_TRAP))) begin
      next_level = LVL_USER_TOP;
    end
  end

  // cpu level and the stack of interrupted levels
  always_ff @(posedge SYS_CLK_IN) begin
    if (SRST_IN) begin
      cpu_level <= LVL_ZERO;
      sp <= '0;
      for (int i = 0; i < STACK_DEPTH; i++) begin
        level_stack[i] <= LVL_ZERO;
      end
    end else if (ack_fire) begin
      // a full stack keeps the level raised but loses the way back
      if (push_ok) begin
        level_stack[sp[SP_W-2:0]] <= cpu_level;
        sp <= sp + SP_W'(1);
      end
      cpu_level <= next_level;
    end else if (ret_fire) begin
      if (pop_ok) begin
        cpu_level <= level_stack[sp[SP_W-2:0] - 4'h1];
        sp <= sp - SP_W'(1);
      end else begin
        cpu_level <= LVL_ZERO;
      end
    end else if (wr_at(OFF_CPU)) begin
      // only user levels are writable, so no write can mask a trap
      cpu_level <= {1'b0, PWDATA_IN[PRIO_W-1:0]};
    end
  end

  // timed disable counter; a new instruction reloads it
  // the count is in clock cycles; traps never look at it
  always_ff @(posedge SYS_CLK_IN) begin
    if (SRST_IN) begin
      dis_count <= '0;
    end else if (TIMED_DISABLE_IN) begin
      dis_count <= TIMED_DISABLE_CYCLES_IN;
    end else if (dis_active) begin
      dis_count <= dis_count - DIS_W'(1);
    end
  end

  // sticky source and trap flags, an arriving event beats the clear
  always_ff @(posedge SYS_CLK_IN) begin
    if (SRST_IN) begin
      user_flag <= '0;
      trap_flag <= '0;
    end else begin
      // accept leaves the flag alone so an uncleared one fires again
      if (wr_at(OFF_FLAGS)) begin
        user_flag <= (user_flag & ~PWDATA_IN[NUM_USER-1:0]) |
          SRC_EVENT_IN;
      end else begin
        user_flag <= user_flag | SRC_EVENT_IN;
      end
      if (wr_at(OFF_CTRL1)) begin
        trap_flag <= (trap_flag &
          ~PWDATA_IN[TRAP_LSB+NUM_TRAP-1:TRAP_LSB]) |
          TRAP_EVENT_IN;
      end else begin
        trap_flag <= trap_flag | TRAP_EVENT_IN;
      end
    end
  end

  // configuration registers
  always_ff @(posedge SYS_CLK_IN) begin
    if (SRST_IN) begin
      nesting_disable <= 1'b0;
      user_enable <= '0;
      imask <= '0;
      for (int u = 0; u < NUM_USER; u++) begin
        user_prio[u] <= PRIO_RESET;
      end
    end else begin
      if (wr_at(OFF_CTRL1)) begin
        nesting_disable <= PWDATA_IN[NEST_DIS_BIT];
      end
      if (wr_at(OFF_ENABLE)) begin
        user_enable <= PWDATA_IN[NUM_USER-1:0];
      end
      if (wr_at(OFF_IMASK)) begin
        imask <= PWDATA_IN[NUM_EV-1:0];
      end
      if (wr_at(OFF_UERR_PRIO)) begin
        user_prio[0] <= PWDATA_IN[PRIO_LSB[0] +: PRIO_W];
      end
      if (wr_at(OFF_PRIO)) begin
        for (int u = 1; u < NUM_USER; u++) begin
          user_prio[u] <= PWDATA_IN[PRIO_LSB[u] +: PRIO_W];
        end
      end
    end
  end

  // controller events for the local interrupt line
  always_comb begin
    ev = '0;
    ev[EV_ACCEPT] = ack_fire;
    ev[EV_TRAP] = ack_fire && (pend_idx < IDX_W'(NUM_TRAP));
    ev[EV_OVERFLOW] = ack_fire && !push_ok;
    // a return lost to a same-cycle accept is not an underflow
    ev[EV_UNDERFLOW] = ret_fire && !ack_fire && !pop_ok;
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (SRST_IN) begin
      istat <= '0;
      IRQ_OUT <= 1'b0;
    end else begin
      if (wr_at(OFF_ISTAT)) begin
        istat <= (istat & ~PWDATA_IN[NUM_EV-1:0]) | ev;
      end else begin
        istat <= istat | ev;
      end
      // a flop stage keeps the output registered, one cycle late
      IRQ_OUT <= |(istat & imask);
    end
  end

  assign CPU_LEVEL_OUT = cpu_level;

  // read mux; unused positions stay zero
  always_comb begin
    rd_data = '0;
    rd_err = 1'b0;
    case (PADDR_IN)
      OFF_CTRL1: begin
        rd_data[NEST_DIS_BIT] = nesting_disable;
        rd_data[TRAP_LSB +: NUM_TRAP] = trap_flag;
      end
      OFF_FLAGS: rd_data[NUM_USER-1:0] = user_flag;
      OFF_ENABLE: rd_data[NUM_USER-1:0] = user_enable;
      OFF_UERR_PRIO: rd_data[PRIO_LSB[0] +: PRIO_W] = user_prio[0];
      OFF_PRIO: begin
        for (int u = 1; u < NUM_USER; u++) begin
          rd_data[PRIO_LSB[u] +: PRIO_W] = user_prio[u];
        end
      end
      OFF_LVLVEC: begin
        rd_data[LVL_LSB +: LVL_W] = CORE_NEW_LEVEL_OUT;
        rd_data[VEC_LSB +: VEC_W] = CORE_VECTOR_OUT;
      end
      OFF_CPU: rd_data[LVL_W-1:0] = cpu_level;
      OFF_DIS: rd_data[DIS_W-1:0] = dis_count;
      OFF_ISTAT: rd_data[NUM_EV-1:0] = istat;
      OFF_IMASK: rd_data[NUM_EV-1:0] = imask;
      // unmapped offsets answer with an error and zero data
      default: rd_err = 1'b1;
    endcase
  end

  // apb answer registered in the first access cycle
  always_ff @(posedge SYS_CLK_IN) begin
    if (SRST_IN) begin
      PREADY_OUT <= 1'b0;
      PRDATA_OUT <= '0;
      PSLVERR_OUT <= 1'b0;
    // pready falls after one cycle, so a held access is answered again every second cycle
    end else if (PSEL_IN && PENABLE_IN && !PREADY_OUT) begin
      PREADY_OUT <= 1'b1;
      PRDATA_OUT <= PWRITE_IN ? '0 : rd_data;
      PSLVERR_OUT <= rd_err;
    end else begin
      PREADY_OUT <= 1'b0;
      PSLVERR_OUT <= 1'b0;
    end
  end
endmodule

//--- test/pric_top_asserts.sv
// concurrent checks on the interrupt controller top ports
module pric_top_asserts
  import pric_pkg::*;
(
  input wire logic SYS_CLK_IN,
  input wire logic SRST_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic [DATA_W-1:0] PRDATA_OUT,
  input wire logic PREADY_OUT,
  input wire logic PSLVERR_OUT,
  input wire logic [NUM_TRAP-1:0] TRAP_EVENT_IN,
  input wire logic IRQ_ACK_IN,
  input wire logic TIMED_DISABLE_IN,
  input wire logic [DIS_W-1:0] TIMED_DISABLE_CYCLES_IN,
  input wire logic CORE_REQ_OUT,
  input wire logic [LVL_W-1:0] CORE_NEW_LEVEL_OUT,
  input wire logic [VEC_W-1:0] CORE_VECTOR_OUT,
  input wire logic [LVL_W-1:0] CPU_LEVEL_OUT
);
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (SRST_IN);
  a_apb_wait: assert property (PSEL_IN && !PENABLE_IN |=>
    !PREADY_OUT ##1 PREADY_OUT) else $error("apb wait state wrong");
  a_err_zero: assert property (PSLVERR_OUT |->
    PREADY_OUT && PRDATA_OUT == 32'h0) else $error("bad error reply");
  a_level_above: assert property (
    CORE_REQ_OUT && $stable(CPU_LEVEL_OUT) |->
    CORE_NEW_LEVEL_OUT > CPU_LEVEL_OUT) else $error("request not above");
  a_ack_raises: assert property (
    IRQ_ACK_IN && CORE_REQ_OUT |=> !CORE_REQ_OUT &&
    CPU_LEVEL_OUT >= $past(CORE_NEW_LEVEL_OUT)) else $error("ack level");
  a_mask_user: assert property (
    CORE_REQ_OUT && CPU_LEVEL_OUT >= 4'h7 && $stable(CPU_LEVEL_OUT) |->
    CORE_VECTOR_OUT < 7'h4) else $error("user source not masked");
  a_trap_level: assert property (
    CORE_REQ_OUT && CORE_VECTOR_OUT < 7'h4 |->
    CORE_NEW_LEVEL_OUT == 4'(CORE_VECTOR_OUT) + 4'h8)
    else $error("trap level wrong");
  a_trap_passes: assert property (
    $rose(|TRAP_EVENT_IN) && CPU_LEVEL_OUT == 4'h7 && !IRQ_ACK_IN
    ##1 !IRQ_ACK_IN |=> CORE_REQ_OUT && CORE_NEW_LEVEL_OUT >= 4'h8)
    else $error("trap masked");
  a_timed_block: assert property (
    TIMED_DISABLE_IN && TIMED_DISABLE_CYCLES_IN > 14'h8 |-> ##2
    (!CORE_REQ_OUT || CORE_NEW_LEVEL_OUT > 4'h6)[*4])
    else $error("timed disable leak");
endmodule
bind pric_top pric_top_asserts u_pric_top_asserts (.*);

//--- test/pric_core_model.sv
// behavioural core that takes interrupts and returns from them
module pric_core_model (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic en_in,
  input wire logic slow_in,
  input wire logic req_in,
  output logic ack_out,
  output logic ret_out
);
  logic [2:0] cnt;
  logic [4:0] depth;
  // a slow core only takes requests every eighth cycle
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ack_out <= 1'b0;
      ret_out <= 1'b0;
      cnt <= 3'h0;
      depth <= 5'h0;
    end else begin
      cnt <= cnt + 3'h1;
      ack_out <= 1'b0;
      ret_out <= 1'b0;
      if (req_in && en_in && !ack_out && (!slow_in || cnt == 3'h7)) begin
        ack_out <= 1'b1;
      end else if (depth != 5'h0 && cnt == 3'h5 && !ack_out) begin
        ret_out <= 1'b1;
        depth <= depth - 5'h1;
      end
      // count only an ack the controller took; a late one is ignored
      if (ack_out && req_in) begin
        depth <= depth + 5'h1;
      end
    end
  end
endmodule

//--- test/test_prioritized_interrupt_controller.sv
// random and directed bench of the interrupt controller
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin \
  error_cnt++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module test_prioritized_interrupt_controller;
  timeunit 1ns;
  timeprecision 1ns;
  import pric_pkg::*;
  logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, tdis = 0;
  logic men = 0, slow = 0, pready, pslverr, req, ack, ret, irq, er;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0, prdata, rd;
  logic [NUM_USER-1:0] src = '0, en, fl;
  logic [NUM_TRAP-1:0] trap = '0;
  logic [DIS_W-1:0] tcyc = '0;
  logic [LVL_W-1:0] nlvl, clvl, cl;
  logic [VEC_W-1:0] vec;
  logic [PRIO_W-1:0] pr [NUM_USER];
  logic [11:0] e;
  int error_cnt = 0, cmp_count = 0, seed = 13012, cyc = 0, nack = 0;
  pric_top u_pric_top (.SYS_CLK_IN(clk), .SRST_IN(rst), .PSEL_IN(psel),
    .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr),
    .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
    .PSLVERR_OUT(pslverr), .SRC_EVENT_IN(src), .TRAP_EVENT_IN(trap),
    .IRQ_ACK_IN(ack), .IRQ_RETURN_IN(ret), .TIMED_DISABLE_IN(tdis),
    .TIMED_DISABLE_CYCLES_IN(tcyc), .CORE_REQ_OUT(req),
    .CORE_NEW_LEVEL_OUT(nlvl), .CORE_VECTOR_OUT(vec),
    .CPU_LEVEL_OUT(clvl), .IRQ_OUT(irq));
  pric_core_model u_pric_core_model (.clk_in(clk), .rst_in(rst),
    .en_in(men), .slow_in(slow), .req_in(req), .ack_out(ack),
    .ret_out(ret));
  initial forever #20 clk = ~clk;
  task automatic results();
    if (error_cnt == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    nack += (ack === 1'b1);
    if (cyc > 6000) begin
      error_cnt++;
      results();
    end
  end
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
      input logic [DATA_W-1:0] d);
    @(posedge clk);
    psel <= 1'b1; pwr <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    // values read here are those sampled at this edge
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; pen <= 1'b0;
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rchk(input logic [ADDR_W-1:0] a, input logic [31:0] x);
    apb(1'b0, a, '0);
    `CHK(rd, x)
  endtask
  task automatic ev(input logic [3:0] s, t, input logic d);
    @(posedge clk);
    src <= s; trap <= t; tdis <= d;
    @(posedge clk);
    src <= '0; trap <= '0; tdis <= 1'b0;
  endtask
  task automatic settle(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  // expected {request, level, vector}; low index wins a tie
  function automatic logic [11:0] best(input logic [3:0] f, c);
    logic [11:0] r;
    r = {1'b0, c, 7'h0};
    for (int k = NUM_USER - 1; k >= 0; k--)
      if (f[k] && en[k] && {1'b0, pr[k]} > c
          && (!r[11] || {1'b0, pr[k]} >= r[10:7]))
        r = {1'b1, 1'b0, pr[k], 7'(4 + k)};
    return r;
  endfunction
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rchk(OFF_UERR_PRIO, 32'h40);
    rchk(OFF_PRIO, 32'h4440);
    wr(OFF_UERR_PRIO, 32'hFFFFFFFF);
    rchk(OFF_UERR_PRIO, 32'h70);
    rchk(8'h3C, 32'h0);
    `CHK(er, 1'b1)
    for (int n = 0; n < 16; n++) begin
      foreach (pr[i]) pr[i] = $random(seed);
      en = $random(seed);
      fl = $random(seed);
      cl = {1'b0, 3'($random(seed))};
      if (n == 0) cl = 4'h7;
      if (n == 1) pr = '{3'h0, 3'h0, 3'h5, 3'h5};
      wr(OFF_FLAGS, 32'hF);
      wr(OFF_CPU, 32'(cl));
      wr(OFF_UERR_PRIO, 32'({pr[0], 4'h0}));
      wr(OFF_PRIO, 32'({pr[1], 1'b0, pr[2], 1'b0, pr[3], 4'h0}));
      wr(OFF_ENABLE, 32'(en));
      ev(fl, 4'h0, 1'b0);
      settle(2);
      e = best(fl, cl);
      `CHK({req, nlvl, vec}, e)
      wr(OFF_LVLVEC, 32'hFFFFFFFF);
      if (e[11]) rchk(OFF_LVLVEC, 32'({e[10:7], 1'b0, e[6:0]}));
    end
    wr(OFF_FLAGS, 32'hF);
    wr(OFF_CPU, 32'h0);
    wr(OFF_ENABLE, 32'h1);
    wr(OFF_UERR_PRIO, 32'h30);
    wr(OFF_IMASK, 32'h1);
    men <= 1'b1;
    ev(4'h1, 4'h0, 1'b0);
    settle(60);
    `CHK(nack > 2, 1'b1)
    `CHK(irq, 1'b1)
    wr(OFF_IMASK, 32'h0);
    settle(2);
    `CHK(irq, 1'b0)
    wr(OFF_FLAGS, 32'h1);
    wr(OFF_ISTAT, 32'hF);
    wr(OFF_IMASK, 32'h1);
    settle(20);
    `CHK({irq, req, clvl}, 6'h0)
    wr(OFF_CTRL1, 32'h8000);
    men <= 1'b1;
    slow <= 1'b1;
    ev(4'h1, 4'h0, 1'b0);
    @(posedge ack);
    settle(1);
    `CHK(clvl, 4'h7)
    wr(OFF_FLAGS, 32'h1);
    wr(OFF_CTRL1, 32'h0);
    men <= 1'b0;
    slow <= 1'b0;
    settle(20);
    `CHK(clvl, 4'h0)
    wr(OFF_CPU, 32'h7);
    wr(OFF_CPU, 32'hF);
    rchk(OFF_CPU, 32'h7);
    ev(4'h0, 4'h2, 1'b0);
    settle(2);
    `CHK({req, nlvl, vec}, {1'b1, 4'h9, 7'h1})
    rchk(OFF_CTRL1, 32'h4);
    wr(OFF_CTRL1, 32'h4);
    rchk(OFF_CTRL1, 32'h0);
    wr(OFF_CPU, 32'h0);
    wr(OFF_UERR_PRIO, 32'h50);
    wr(OFF_PRIO, 32'h7000);
    wr(OFF_ENABLE, 32'h3);
    tcyc <= 14'd40;
    ev(4'h0, 4'h0, 1'b1);
    ev(4'h1, 4'h0, 1'b0);
    settle(2);
    `CHK(req, 1'b0)
    ev(4'h2, 4'h0, 1'b0);
    settle(2);
    `CHK({req, nlvl, vec}, {1'b1, 4'h7, 7'h5})
    wr(OFF_FLAGS, 32'h2);
    settle(40);
    `CHK({req, nlvl, vec}, {1'b1, 4'h5, 7'h4})
    results();
  end
endmodule
